// ==== inc/mtxs_pkg.sv ====
`include "mtxs_regs.svh"

package mtxs_pkg;

  // ----------------------------------------------------------------
  // Bus channel states
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    MTXS_WR_IDLE = 2'h0,
    MTXS_WR_ADDR = 2'h1,
    MTXS_WR_RESP = 2'h3,
    MTXS_WR_DATA = 2'h2
  } mtxs_wr_e;

  typedef enum logic {
    MTXS_RD_IDLE = 1'h0,
    MTXS_RD_DATA = 1'h1
  } mtxs_rd_e;

  // Address decode result
  typedef enum logic [2:0] {
    MTXS_SEL_NONE = 3'h0,
    MTXS_SEL_FRAME = 3'h1,
    MTXS_SEL_BYTE = 3'h2,
    MTXS_SEL_GOOD = 3'h3,
    MTXS_SEL_CTRL = 3'h4,
    MTXS_SEL_WRAP = 3'h5
  } mtxs_sel_e;

  // ----------------------------------------------------------------
  // Carriers
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [`MTXS_ADDR_W-1:0] addr;
  } mtxs_addr_s;

  typedef struct packed {
    logic [31:0] data;
    logic [3:0] strb;
  } mtxs_wdata_s;

  // Frame is bit 0, byte bit 1, good byte bit 2
  typedef struct packed {
    logic good;
    logic tx_byte;
    logic frame;
  } mtxs_evt_s;

  typedef struct packed {
    logic [`MTXS_NUM_CNT-1:0][31:0] count;
    logic [`MTXS_NUM_CNT-1:0] enable;
    logic [`MTXS_NUM_CNT-1:0] wrap;
    mtxs_wr_e wr_st;
    mtxs_addr_s aw;
    mtxs_wdata_s w;
    logic [1:0] bresp;
    mtxs_rd_e rd_st;
    logic [31:0] rdata;
    logic [1:0] rresp;
  } mtxs_state_s;

endpackage

// ==== inc/mtxs_regs.svh ====
`ifndef MTXS_REGS_SVH
`define MTXS_REGS_SVH

// ----------------------------------------------------------------
// Register map and field layout
// ----------------------------------------------------------------
`define MTXS_ADDR_W 12
`define MTXS_FRAME_OFS 12'h300
`define MTXS_BYTE_OFS 12'h308
`define MTXS_GOOD_OFS 12'h30C
`define MTXS_CTRL_OFS 12'h340
`define MTXS_WRAP_OFS 12'h344

// Counter index, also bit position in the control and wrap words
`define MTXS_FRAME_BIT 0
`define MTXS_BYTE_BIT 1
`define MTXS_GOOD_BIT 2
`define MTXS_NUM_CNT 3

// ----------------------------------------------------------------
// Reset values and bus answers
// ----------------------------------------------------------------
`define MTXS_CNT_RST 32'h0000_0000
`define MTXS_CTRL_RST 3'h7
`define MTXS_WRAP_RST 3'h0
`define MTXS_RESP_OKAY 2'h0
`define MTXS_RESP_SLVERR 2'h2

`endif

// ==== testbench/mtxs_chk.sv ====
module mtxs_chk (
  input wire logic ref_clk_in, // Clock
  input wire logic reset_in, // Reset
  input wire logic s_axi_awvalid_in, // AW valid
  input wire logic s_axi_awready_out, // AW ready
  input wire logic s_axi_wvalid_in, // W valid
  input wire logic s_axi_wready_out, // W ready
  input wire logic s_axi_bvalid_out, // B valid
  input wire logic s_axi_bready_in, // B ready
  input wire logic s_axi_arvalid_in, // AR valid
  input wire mtxs_pkg::mtxs_addr_s s_axi_ar_in, // AR address
  input wire logic s_axi_arready_out, // AR ready
  input wire logic s_axi_rvalid_out, // R valid
  input wire logic [31:0] s_axi_rdata_out, // R data
  input wire logic [1:0] s_axi_rresp_out, // R response
  input wire logic s_axi_rready_in // R ready
);
  timeunit 1ns;
  timeprecision 1ps;
  // ----------------------------------------
  // Bus timing and decode checks
  // ----------------------------------------
  logic ar_t;
  logic [9:0] wa;
  default clocking @(posedge ref_clk_in); endclocking
  default disable iff (reset_in);
  // Taken read and its word index
  assign ar_t = s_axi_arvalid_in && s_axi_arready_out;
  assign wa = s_axi_ar_in.addr[11:2];
  property p_rlat; ar_t |=> s_axi_rvalid_out; endproperty
  a_rlat: assert property (p_rlat) else $error("rvalid late");
  property p_rhold; s_axi_rvalid_out && !s_axi_rready_in
    |=> s_axi_rvalid_out && $stable(s_axi_rdata_out); endproperty
  a_rhold: assert property (p_rhold) else $error("rdata moved");
  property p_rblk; s_axi_rvalid_out |-> !s_axi_arready_out; endproperty
  a_rblk: assert property (p_rblk) else $error("arready early");
  property p_gap; ar_t && wa == 10'h0C1
    |=> s_axi_rresp_out == 2'h2 && s_axi_rdata_out == 32'h0; endproperty
  a_gap: assert property (p_gap) else $error("0x304 mapped");
  property p_frm; ar_t && wa == 10'h0C0 |=> s_axi_rresp_out == 2'h0;
  endproperty
  a_frm: assert property (p_frm) else $error("0x300 refused");
  property p_byt; ar_t && wa == 10'h0C2 |=> s_axi_rresp_out == 2'h0;
  endproperty
  a_byt: assert property (p_byt) else $error("0x308 refused");
  property p_good; ar_t && wa == 10'h0C3 |=> s_axi_rresp_out == 2'h0;
  endproperty
  a_good: assert property (p_good) else $error("0x30C refused");
  property p_bblk; s_axi_bvalid_out
    |-> !s_axi_awready_out && !s_axi_wready_out; endproperty
  a_bblk: assert property (p_bblk) else $error("write ready early");
  property p_bdone; s_axi_bvalid_out && s_axi_bready_in
    |=> !s_axi_bvalid_out; endproperty
  a_bdone: assert property (p_bdone) else $error("bvalid stuck");
endmodule

bind mtxs_counters mtxs_chk u_chk (
  .ref_clk_in(ref_clk_in),
  .reset_in(reset_in),
  .s_axi_awvalid_in(s_axi_awvalid_in),
  .s_axi_awready_out(s_axi_awready_out),
  .s_axi_wvalid_in(s_axi_wvalid_in),
  .s_axi_wready_out(s_axi_wready_out),
  .s_axi_bvalid_out(s_axi_bvalid_out),
  .s_axi_bready_in(s_axi_bready_in),
  .s_axi_arvalid_in(s_axi_arvalid_in),
  .s_axi_ar_in(s_axi_ar_in),
  .s_axi_arready_out(s_axi_arready_out),
  .s_axi_rvalid_out(s_axi_rvalid_out),
  .s_axi_rdata_out(s_axi_rdata_out),
  .s_axi_rresp_out(s_axi_rresp_out),
  .s_axi_rready_in(s_axi_rready_in)
);

// ==== testbench/mtxs_mac_src.sv ====
module mtxs_mac_src (
  input wire logic ref_clk_in, // Clock
  output mtxs_pkg::mtxs_evt_s tx_evt_out // Transmit strobes
);
  timeunit 1ns;
  timeprecision 1ps;
  // Strobes stay low between frames
  initial tx_evt_out = '0;
  // One byte a cycle, frame strobe on the last byte; gap sets pace
  task automatic send(input int n, input int nb, input logic g,
                      input int gap);
    for (int f = 0; f < n; f++) begin
      for (int b = 0; b < nb; b++) begin
        @(posedge ref_clk_in);
        tx_evt_out <= '{good: g, tx_byte: 1'b1,
                        frame: b == nb - 1};
      end
      @(posedge ref_clk_in);
      tx_evt_out <= '0;
      repeat (gap) @(posedge ref_clk_in);
    end
  endtask
endmodule

// ==== testbench/testbench.sv ====
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  // ----------------------------------------
  // Signals and instances
  // ----------------------------------------
  logic ref_clk_in, reset_in, awv, wv, brdy, arv, rrdy, awr, wrdy, bv;
  logic arr, rv;
  logic [1:0] bresp, rresp, r;
  logic [31:0] rdata, d, ef, eb, eg;
  mtxs_pkg::mtxs_addr_s aw, ar;
  mtxs_pkg::mtxs_wdata_s w;
  mtxs_pkg::mtxs_evt_s evt;
  int err_count, check_count, cyc;
  mtxs_mac_src u_src (.ref_clk_in(ref_clk_in), .tx_evt_out(evt));
  mtxs_counters dut (.ref_clk_in(ref_clk_in), .reset_in(reset_in),
    .tx_evt_in(evt), .s_axi_awvalid_in(awv), .s_axi_aw_in(aw),
    .s_axi_awready_out(awr), .s_axi_wvalid_in(wv), .s_axi_w_in(w),
    .s_axi_wready_out(wrdy), .s_axi_bvalid_out(bv),
    .s_axi_bresp_out(bresp), .s_axi_bready_in(brdy),
    .s_axi_arvalid_in(arv), .s_axi_ar_in(ar), .s_axi_arready_out(arr),
    .s_axi_rvalid_out(rv), .s_axi_rdata_out(rdata),
    .s_axi_rresp_out(rresp), .s_axi_rready_in(rrdy));
  initial begin
    ref_clk_in = 1'b0;
    forever #4 ref_clk_in = ~ref_clk_in;
  end
  task automatic chk(string n, logic [31:0] e, logic [31:0] g);
    check_count++;
    if (g !== e) begin
      err_count++;
      $display("[ERR] %s exp %h got %h", n, e, g);
    end
  endtask
  // Ready sampled at the falling edge, so the taking edge is known
  task automatic wr(logic [11:0] a, logic [31:0] dw);
    logic ta, tw, v;
    @(posedge ref_clk_in);
    aw <= '{addr: a};
    w <= '{data: dw, strb: 4'hF};
    awv <= 1'b1;
    wv <= 1'b1;
    brdy <= 1'b1;
    do begin
      @(negedge ref_clk_in);
      ta = awr;
      tw = wrdy;
      v = bv;
      r = bresp;
      @(posedge ref_clk_in);
      if (ta) awv <= 1'b0;
      if (tw) wv <= 1'b0;
    end while (!v);
    brdy <= 1'b0;
  endtask
  task automatic rd(logic [11:0] a);
    logic t, v;
    @(posedge ref_clk_in);
    ar <= '{addr: a};
    arv <= 1'b1;
    rrdy <= 1'b1;
    do begin
      @(negedge ref_clk_in);
      t = arr;
      v = rv;
      d = rdata;
      r = rresp;
      @(posedge ref_clk_in);
      if (t) arv <= 1'b0;
    end while (!v);
    rrdy <= 1'b0;
  endtask
  // Counter words come back with the top byte on the lowest lane
  task automatic rdc(logic [11:0] a, string n, logic [31:0] e);
    rd(a);
    chk(n, {e[7:0], e[15:8], e[23:16], e[31:24]}, d);
    chk("rresp", 32'h0, {30'h0, r});
  endtask
  task automatic rdall;
    rdc(12'h300, "frames", ef);
    rdc(12'h308, "bytes", eb);
    rdc(12'h30C, "good", eg);
  endtask
  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  // Reset values, then the hole between the first two counters
  task automatic t_rst;
    rdall;
    rd(12'h304);
    chk("gap resp", 32'h2, {30'h0, r});
    chk("gap data", 32'h0, d);
    wr(12'h304, 32'hFFFF_FFFF);
    chk("gap bresp", 32'h2, {30'h0, r});
    rd(12'h340);
    chk("enable", 32'h7, d);
  endtask
  // Short frames, then one long enough to carry into the second
  // byte of the byte counters, so lane order is seen beyond byte 0
  task automatic t_cnt;
    u_src.send(3, 5, 1'b1, 0);
    u_src.send(2, 4, 1'b0, 3);
    u_src.send(1, 300, 1'b1, 0);
    ef += 6;
    eb += 323;
    eg += 315;
    rdall;
    rd(12'h344);
    chk("wrap", 32'h0, d);
  endtask
  task automatic t_ro;
    wr(12'h300, 32'hFFFF_FFFF);
    chk("bresp", 32'h0, {30'h0, r});
    wr(12'h30C, 32'h0);
    chk("bresp", 32'h0, {30'h0, r});
    rdall;
    rdall;
  endtask
  // Frame counting paused, bytes still counted; the enable is left
  // cleared so the next reset must bring it back
  task automatic t_en;
    wr(12'h340, 32'h6);
    rd(12'h340);
    chk("enable", 32'h6, d);
    u_src.send(1, 2, 1'b1, 0);
    eb += 2;
    eg += 2;
    rdall;
  endtask
  task automatic t_rst2;
    @(posedge ref_clk_in);
    reset_in <= 1'b1;
    repeat (2) @(posedge ref_clk_in);
    reset_in <= 1'b0;
    {ef, eb, eg} = '0;
    rdall;
    rd(12'h340);
    chk("enable", 32'h7, d);
  endtask
  task automatic summarize;
    $display("checks %0d errors %0d", check_count, err_count);
    if (err_count == 0 && check_count > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  // Hang guard, far above the few hundred cycles needed; the whole
  // run also stays far inside one counter wrap
  always @(posedge ref_clk_in) begin
    cyc <= cyc + 1;
    if (cyc == 5000) begin
      err_count++;
      summarize;
    end
  end
  initial begin
    {reset_in, awv, wv, brdy, arv, rrdy} = 6'h20;
    {aw, ar, w, ef, eb, eg} = '0;
    repeat (20) @(posedge ref_clk_in);
    reset_in <= 1'b0;
    t_rst;
    t_cnt;
    t_ro;
    t_en;
    t_rst2;
    summarize;
  end
endmodule

// ==== verilog/mtxs_counters.sv ====
// Function
// [R1] Count every transmitted frame in a 32-bit counter, one per frame.
// [R2] Count every transmitted byte in a separate 32-bit counter.
// [R3] Counters start at zero; only device reset clears them.
// [R4] No saturation: all-ones plus one wraps to zero.
// [R5] Software keeps measurement periods shorter than a full wrap.
// [R6] Software records start values and allows for a wrap.
// [R7] Frame counter at 0300h-0303h, bits 31:24 at lowest address.
// [R8] Byte counter at 0308h-030Bh, most significant byte first.
// [R9] Good byte counter from 030Ch, same byte order.
// [R10] Good byte counter adds one per valid byte, same clear/wrap.
// [R11] Counter reads have no side effect; counter writes are ignored.
//
// The implementer's own choice: the AXI4-Lite slave port.
`include "mtxs_regs.svh"

module mtxs_counters (
  input wire logic ref_clk_in, // 125 MHz clock
  input wire logic reset_in, // Async reset, active high
  input wire mtxs_pkg::mtxs_evt_s tx_evt_in, // Transmit path strobes
  input wire logic s_axi_awvalid_in, // Write address valid
  input wire mtxs_pkg::mtxs_addr_s s_axi_aw_in, // Write address
  output logic s_axi_awready_out, // Write address ready
  input wire logic s_axi_wvalid_in, // Write data valid
  input wire mtxs_pkg::mtxs_wdata_s s_axi_w_in, // Write data, strobes
  output logic s_axi_wready_out, // Write data ready
  output logic s_axi_bvalid_out, // Write response valid
  output logic [1:0] s_axi_bresp_out, // Write response
  input wire logic s_axi_bready_in, // Write response ready
  input wire logic s_axi_arvalid_in, // Read address valid
  input wire mtxs_pkg::mtxs_addr_s s_axi_ar_in, // Read address
  output logic s_axi_arready_out, // Read address ready
  output logic s_axi_rvalid_out, // Read data valid
  output logic [31:0] s_axi_rdata_out, // Read data
  output logic [1:0] s_axi_rresp_out, // Read response
  input wire logic s_axi_rready_in // Read data ready
);

  // ----------------------------------------------------------------
  // Reset image of the whole state
  // ----------------------------------------------------------------
  // The only place a count is cleared to zero; software writes and
  // reads have no path here
  localparam mtxs_pkg::mtxs_state_s ST_RST = '{
    count: {`MTXS_NUM_CNT{`MTXS_CNT_RST}}, // [R3]
    enable: `MTXS_CTRL_RST,
    wrap: `MTXS_WRAP_RST,
    wr_st: mtxs_pkg::MTXS_WR_IDLE,
    aw: '0,
    w: '0,
    bresp: `MTXS_RESP_OKAY,
    rd_st: mtxs_pkg::MTXS_RD_IDLE,
    rdata: '0,
    rresp: `MTXS_RESP_OKAY
  };

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  // Word decode; low two address bits are ignored, every
  // register being one aligned word
  function automatic mtxs_pkg::mtxs_sel_e decode(
    input logic [`MTXS_ADDR_W-1:0] addr
  );
    logic [`MTXS_ADDR_W-1:0] word;
    word = {addr[`MTXS_ADDR_W-1:2], 2'h0};
    unique case (word)
      `MTXS_FRAME_OFS: decode = mtxs_pkg::MTXS_SEL_FRAME; // [R7]
      `MTXS_BYTE_OFS: decode = mtxs_pkg::MTXS_SEL_BYTE; // [R8]
      `MTXS_GOOD_OFS: decode = mtxs_pkg::MTXS_SEL_GOOD; // [R9]
      `MTXS_CTRL_OFS: decode = mtxs_pkg::MTXS_SEL_CTRL;
      `MTXS_WRAP_OFS: decode = mtxs_pkg::MTXS_SEL_WRAP;
      default: decode = mtxs_pkg::MTXS_SEL_NONE;
    endcase
  endfunction

  // Most significant byte to the lowest byte address, so the
  // byte at offset +0 on the little-endian bus is bits 31:24
  function automatic logic [31:0] msb_first(input logic [31:0] c);
    msb_first = {c[7:0], c[15:8], c[23:16], c[31:24]}; // [R7] [R8]
  endfunction

  // Wrapping increment; the carry out is dropped on purpose, so a
  // counter at all ones reads zero after its next strobe
  function automatic logic [31:0] bump(input logic [31:0] c);
    logic [32:0] sum;
    sum = {1'b0, c} + 33'h0_0000_0001;
    bump = sum[31:0]; // [R4]
  endfunction

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  // Whole registered image and its next value; every flip-flop of
  // the block lives in this one struct
  mtxs_pkg::mtxs_state_s state_q;
  mtxs_pkg::mtxs_state_s state_d;

  // Bus handshakes, merged write halves and decoded selects
  logic aw_hs;
  logic w_hs;
  logic wr_go;
  logic [`MTXS_ADDR_W-1:0] wr_addr;
  mtxs_pkg::mtxs_wdata_s wr_data;
  mtxs_pkg::mtxs_sel_e wr_sel;
  mtxs_pkg::mtxs_sel_e rd_sel;
  logic [`MTXS_NUM_CNT-1:0] evt_vec;
  logic [`MTXS_NUM_CNT-1:0] wrap_set;
  logic [`MTXS_NUM_CNT-1:0] wrap_clr;

  // ----------------------------------------------------------------
  // Handshake outputs
  // ----------------------------------------------------------------
  // Address and data each accepted once per write, in either order
  // Both readies drop while a response is pending: one write at a time
  assign s_axi_awready_out = (state_q.wr_st == mtxs_pkg::MTXS_WR_IDLE)
                          || (state_q.wr_st == mtxs_pkg::MTXS_WR_DATA);
  assign s_axi_wready_out = (state_q.wr_st == mtxs_pkg::MTXS_WR_IDLE)
                         || (state_q.wr_st == mtxs_pkg::MTXS_WR_ADDR);
  assign s_axi_bvalid_out = (state_q.wr_st == mtxs_pkg::MTXS_WR_RESP);
  assign s_axi_arready_out = (state_q.rd_st == mtxs_pkg::MTXS_RD_IDLE);
  assign s_axi_rvalid_out = (state_q.rd_st == mtxs_pkg::MTXS_RD_DATA);

  // Data and responses straight from flip-flops
  assign s_axi_bresp_out = state_q.bresp;
  assign s_axi_rdata_out = state_q.rdata;
  assign s_axi_rresp_out = state_q.rresp;

  // ----------------------------------------------------------------
  // Write path decode
  // ----------------------------------------------------------------
  // Held halves are used when the two arrive in separate cycles
  assign aw_hs = s_axi_awvalid_in && s_axi_awready_out;
  assign w_hs = s_axi_wvalid_in && s_axi_wready_out;
  assign wr_addr = (state_q.wr_st == mtxs_pkg::MTXS_WR_ADDR)
                 ? state_q.aw.addr : s_axi_aw_in.addr;
  assign wr_data = (state_q.wr_st == mtxs_pkg::MTXS_WR_DATA)
                 ? state_q.w : s_axi_w_in;
  assign wr_sel = decode(wr_addr);
  // Read address is decoded live; arready is high only when idle,
  // so it is used at the very edge that takes it
  assign rd_sel = decode(s_axi_ar_in.addr);
  // Strobes are level sampled: a strobe held N cycles counts N
  // times, so the transmit path must give one pulse per unit
  assign evt_vec = tx_evt_in;

  // Write completes when the second half lands
  // No write effect while the response is still waiting
  always_comb begin
    unique case (state_q.wr_st)
      mtxs_pkg::MTXS_WR_IDLE: wr_go = aw_hs && w_hs;
      mtxs_pkg::MTXS_WR_ADDR: wr_go = w_hs;
      mtxs_pkg::MTXS_WR_DATA: wr_go = aw_hs;
      mtxs_pkg::MTXS_WR_RESP: wr_go = 1'b0;
    endcase
  end

  // ----------------------------------------------------------------
  // Wrap-seen flags
  // ----------------------------------------------------------------
  // A flag is raised when its counter rolls from all ones; the
  // write-one clear loses to a wrap in the same cycle
  // Software reading these can tell a rollover from a slow link
  always_comb begin
    wrap_set = '0;
    wrap_clr = '0;
    for (int i = 0; i < `MTXS_NUM_CNT; i++) begin
      wrap_set[i] = evt_vec[i] && state_q.enable[i]
                 && (&state_q.count[i]); // [R4]
    end
    if (wr_go && (wr_sel == mtxs_pkg::MTXS_SEL_WRAP)
        && wr_data.strb[0]) begin
      wrap_clr = wr_data.data[`MTXS_NUM_CNT-1:0];
    end
  end

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb begin
    state_d = state_q;

    // Counting: one per strobe, no clear path but reset
    // A strobe that meets a cleared enable bit is lost, not held
    for (int i = 0; i < `MTXS_NUM_CNT; i++) begin
      if (evt_vec[i] && state_q.enable[i]) begin
        state_d.count[i] = bump(state_q.count[i]); // [R1] [R2] [R10]
      end
    end
    state_d.wrap = (state_q.wrap & ~wrap_clr) | wrap_set;

    // Write channel; a half that arrives alone is parked here and
    // the other half completes the write through wr_go below
    unique case (state_q.wr_st)
      mtxs_pkg::MTXS_WR_IDLE: begin
        if (aw_hs && !w_hs) begin
          state_d.aw = s_axi_aw_in;
          state_d.wr_st = mtxs_pkg::MTXS_WR_ADDR;
        end else if (w_hs && !aw_hs) begin
          state_d.w = s_axi_w_in;
          state_d.wr_st = mtxs_pkg::MTXS_WR_DATA;
        end
      end
      mtxs_pkg::MTXS_WR_ADDR: begin
        // Address parked, waiting for the data
        state_d.wr_st = state_q.wr_st;
      end
      mtxs_pkg::MTXS_WR_DATA: begin
        // Data parked, waiting for the address
        state_d.wr_st = state_q.wr_st;
      end
      mtxs_pkg::MTXS_WR_RESP: begin
        if (s_axi_bready_in) begin
          state_d.wr_st = mtxs_pkg::MTXS_WR_IDLE;
        end
      end
    endcase

    // Write effect; counter words accept and drop the data. They
    // answer OKAY so a sweep of the map sees no error, yet the
    // stored counts never move
    if (wr_go) begin
      state_d.wr_st = mtxs_pkg::MTXS_WR_RESP;
      unique case (wr_sel)
        mtxs_pkg::MTXS_SEL_FRAME,
        mtxs_pkg::MTXS_SEL_BYTE,
        mtxs_pkg::MTXS_SEL_GOOD: begin
          state_d.bresp = `MTXS_RESP_OKAY; // [R11]
        end
        mtxs_pkg::MTXS_SEL_CTRL: begin
          state_d.bresp = `MTXS_RESP_OKAY;
          // Enable bits live in byte lane 0 only
          if (wr_data.strb[0]) begin
            state_d.enable = wr_data.data[`MTXS_NUM_CNT-1:0];
          end
        end
        mtxs_pkg::MTXS_SEL_WRAP: begin
          // The clear itself is applied with the wrap flags above
          state_d.bresp = `MTXS_RESP_OKAY;
        end
        mtxs_pkg::MTXS_SEL_NONE: begin
          // Unmapped word: refused, nothing stored
          state_d.bresp = `MTXS_RESP_SLVERR;
        end
      endcase
    end

    // Read channel; counter value is the one before any
    // increment in the same cycle, and reading changes nothing
    // Bytes of one count leave together, never torn across reads
    unique case (state_q.rd_st)
      mtxs_pkg::MTXS_RD_IDLE: begin
        if (s_axi_arvalid_in) begin
          state_d.rd_st = mtxs_pkg::MTXS_RD_DATA;
          state_d.rresp = `MTXS_RESP_OKAY;
          unique case (rd_sel)
            mtxs_pkg::MTXS_SEL_FRAME: begin
              state_d.rdata = msb_first(
                state_q.count[`MTXS_FRAME_BIT]); // [R7] [R11]
            end
            mtxs_pkg::MTXS_SEL_BYTE: begin
              state_d.rdata = msb_first(
                state_q.count[`MTXS_BYTE_BIT]); // [R8] [R11]
            end
            mtxs_pkg::MTXS_SEL_GOOD: begin
              state_d.rdata = msb_first(
                state_q.count[`MTXS_GOOD_BIT]); // [R9] [R11]
            end
            mtxs_pkg::MTXS_SEL_CTRL: begin
              state_d.rdata = {29'h0000_0000, state_q.enable};
            end
            mtxs_pkg::MTXS_SEL_WRAP: begin
              state_d.rdata = {29'h0000_0000, state_q.wrap};
            end
            mtxs_pkg::MTXS_SEL_NONE: begin
              // Zero data with SLVERR, so a stray read
              // cannot pass for a live count
              state_d.rdata = 32'h0000_0000;
              state_d.rresp = `MTXS_RESP_SLVERR;
            end
          endcase
        end
      end
      mtxs_pkg::MTXS_RD_DATA: begin
        // Data and response hold until the master takes them
        if (s_axi_rready_in) begin
          state_d.rd_st = mtxs_pkg::MTXS_RD_IDLE;
        end
      end
    endcase
  end

  // ----------------------------------------------------------------
  // State register
  // ----------------------------------------------------------------
  // Reset is the only way the counters are cleared. Its release
  // is taken as synchronous to the clock already; a release near
  // an edge could leave the counts disagreeing
  always_ff @(posedge ref_clk_in or posedge reset_in) begin
    if (reset_in) begin
      state_q <= ST_RST; // [R3]
    end else begin
      state_q <= state_d;
    end
  end

endmodule
